// ---- rtl/swpa_pkg.sv ----
`default_nettype none
package swpa_pkg;

  // ---------------------------------------------------------------
  // register map
  // ---------------------------------------------------------------
  localparam int NREG = 32;
  localparam int NMEAN = 4;
  typedef logic [15:0] swpa_adr_t;
  localparam swpa_adr_t REG_ADR [NREG] = '{
    16'h3800, 16'h3801, 16'h3802, 16'h3803, 16'h3804, 16'h3805,
    16'h3806, 16'h3807, 16'h3808, 16'h3809, 16'h380A, 16'h380B,
    16'h380C, 16'h380D, 16'h380E, 16'h380F, 16'h3810, 16'h3811,
    16'h3812, 16'h3813, 16'h3814, 16'h3815, 16'h382A, 16'h382B,
    16'h5040, 16'h5041, 16'h5680, 16'h5681, 16'h5683, 16'h5684,
    16'h5685, 16'h5687};
  localparam logic [7:0] REG_RST [NREG] = '{
    8'h00, 8'h00, 8'h00, 8'h04, 8'h07, 8'hF3, 8'h04, 8'h43,
    8'h07, 8'h80, 8'h04, 8'h38, 8'h04, 8'h38, 8'h04, 8'h58,
    8'h00, 8'h08, 8'h00, 8'h04, 8'h01, 8'h01, 8'h01, 8'h01,
    8'h00, 8'h41, 8'h00, 8'h00, 8'h00, 8'h01, 8'h40, 8'hF0};
  localparam logic [7:0] REG_MASK [NREG] = '{
    8'h0F, 8'hFF, 8'h0F, 8'hFF, 8'h0F, 8'hFF, 8'h0F, 8'hFF,
    8'h0F, 8'hFF, 8'h0F, 8'hFF, 8'hFF, 8'hFF, 8'h7F, 8'hFF,
    8'h0F, 8'hFF, 8'h0F, 8'hFF, 8'h1F, 8'h1F, 8'h1F, 8'h1F,
    8'hFF, 8'h7F, 8'h01, 8'hFF, 8'hFF, 8'h01, 8'hFF, 8'hFF};
  localparam swpa_adr_t MEAN_ADR = 16'h5693;

  // index of the first byte of each field inside the map
  localparam int IX_CBEGC = 0;
  localparam int IX_CBEGR = 2;
  localparam int IX_CLASTC = 4;
  localparam int IX_CLASTR = 6;
  localparam int IX_OW = 8;
  localparam int IX_OH = 10;
  localparam int IX_LLEN = 12;
  localparam int IX_FLEN = 14;
  localparam int IX_CSH = 16;
  localparam int IX_RSH = 18;
  localparam int IX_CSO = 20;
  localparam int IX_CSE = 21;
  localparam int IX_RSO = 22;
  localparam int IX_RSE = 23;
  localparam int IX_PCTL = 24;
  localparam int IX_PAUX = 25;
  localparam int IX_MX = 26;
  localparam int IX_MY = 28;
  localparam int IX_MW = 29;
  localparam int IX_MH = 31;

  // ---------------------------------------------------------------
  // field positions
  // ---------------------------------------------------------------
  localparam int PC_EN = 7;
  localparam int PC_ROLL = 6;
  localparam int PC_TRANS = 5;
  localparam int PC_MONO = 4;
  localparam int PC_STY = 2;
  localparam int PC_MODE = 0;
  localparam int AUX_CUT = 6;
  localparam int AUX_LSB0 = 5;
  localparam int AUX_SAME = 4;

  typedef enum logic [1:0] {
    PAT_BAR = 2'h0, PAT_RAND = 2'h1, PAT_SQUARE = 2'h2, PAT_BLACK = 2'h3
  } swpa_pat_t;

  // ---------------------------------------------------------------
  // pattern constants
  // ---------------------------------------------------------------
  localparam int PIXW = 10;
  localparam int BAR_SHIFT = 8;
  localparam int TILE_BIT = 7;
  localparam logic [23:0] BAR_TABLE = 24'h0654F7;
  localparam logic [11:0] ROLL_H = 12'h040;
  localparam logic [11:0] ROLL_STEP = 12'h008;
  localparam logic [11:0] LFSR_FILL = 12'hACE;
  localparam logic [15:0] LFSR_TAPS = 16'hB400;
  localparam logic [15:0] LFSR_RST = 16'hACE1;
  localparam int FIFO_DEPTH = 8;

  typedef struct packed {
    logic sof;
    logic [PIXW-1:0] data;
  } swpa_pix_t;

  typedef struct packed {
    logic [11:0] cbeg_c, cbeg_r, clast_c, clast_r, ow, oh;
    logic [15:0] llen;
    logic [14:0] flen;
    logic [11:0] csh, rsh;
    logic [4:0] cso, cse, rso, rse;
    logic [7:0] pctl, paux;
    logic [8:0] mx;
    logic [7:0] my;
    logic [8:0] mw;
    logic [7:0] mh;
  } swpa_cfg_t;

endpackage
`default_nettype wire

// ---- rtl/swpa_fifo.sv ----
`default_nettype none
module swpa_fifo #(
  parameter int W = 11,
  parameter int D = 8
) (
  input wire logic ref_clk,
  input wire logic srst,
  input wire logic wr_vld,
  output logic wr_rdy,
  input wire logic [W-1:0] wr_data,
  output logic rd_vld,
  input wire logic rd_rdy,
  output logic [W-1:0] rd_data
);
  localparam int AW = $clog2(D);
  localparam logic [AW:0] ROOM = (AW+1)'(D - 1);

  logic [W-1:0] mem_r [D];
  logic [AW-1:0] wp_r, rp_r;
  logic [AW:0] cnt_r, cnt_nxt;
  logic push, pop;

  assign push = wr_vld && (cnt_r < (AW+1)'(D));
  assign pop = (cnt_r != '0) && (!rd_vld || rd_rdy);
  assign cnt_nxt = (AW+1)'(cnt_r + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop});

  always_ff @(posedge ref_clk) begin
    if (push) begin
      mem_r[wp_r] <= wr_data;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (srst) begin
      wp_r <= '0;
      rp_r <= '0;
      cnt_r <= '0;
    end else begin
      wp_r <= wp_r + AW'(push);
      rp_r <= rp_r + AW'(pop);
      cnt_r <= cnt_nxt;
    end
  end

  // one slot kept free for the word already in flight upstream
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      wr_rdy <= 1'b0;
    end else begin
      wr_rdy <= cnt_nxt < ROOM;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (srst) begin
      rd_vld <= 1'b0;
      rd_data <= '0;
    end else if (pop) begin
      rd_vld <= 1'b1;
      rd_data <= mem_r[rp_r];
    end else if (rd_rdy) begin
      rd_vld <= 1'b0;
    end
  end
endmodule
`default_nettype wire

// ---- rtl/swpa_top.sv ----
// Summary of operation
// - visible region bounded by column/row first and last within the array
// - pixels outside the region are dropped; line and frame counts unchanged
// - 12-bit crop begin column/row, two bytes each; reset 0 and 4
// - 12-bit crop last column/row; reset 0x7F3 and 0x443
// - 12-bit output width and height; reset 1920 by 1080
// - 16-bit line length, 15-bit frame length with 7-bit top byte
// - 12-bit column and row shifts; reset 8 and 4
// - 5-bit odd/even column and row step increments, reset to 1
// - pattern enable bit 7 replaces sensor data with test pattern
// - pattern type bits 1:0: bars, random, squares, black
// - bar style bits 3:2: plain, darker down, darker left, darker up
// - bit 5 blends pattern with sensor data (transparent effect)
// - bit 6 overlays an inverted bar rolling downward each frame
// - random pattern either changes every frame or repeats per frame
// - aux bit 4 restarts the random generator from the 4-bit seed
// - aux bit 6 cuts pixels beyond output size; set after reset
// - aux bit 5 forces the two low bits of output pixels to zero
// - frame brightness averages are produced for exposure control
// - averaging window: 9-bit x, 8-bit y, 9-bit width, 8-bit height
// - blue, green, red, luma averages read at four consecutive addresses
// - register writes take effect at the next start-of-frame pixel
`default_nettype none
module swpa_top
  import swpa_pkg::*;
#(
  parameter int DEPTH = FIFO_DEPTH
) (
  input wire logic ref_clk,
  input wire logic srst,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [15:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  output logic [7:0] reg_rdata_r,
  input wire logic in_vld,
  output logic in_rdy,
  input wire swpa_pix_t in_pix,
  output logic out_vld,
  input wire logic out_rdy,
  output swpa_pix_t out_pix
);

  // ---------------------------------------------------------------
  // register file
  // ---------------------------------------------------------------
  logic [7:0] regs_r [NREG];
  logic [7:0] mean_r [NMEAN];
  int acc_idx;
  logic [15:0] mean_off;

  function automatic int reg_index(swpa_adr_t a);
    int r;
    r = -1;
    for (int i = 0; i < NREG; i++) begin
      if (REG_ADR[i] == a) begin
        r = i;
      end
    end
    return r;
  endfunction

  assign acc_idx = reg_index(reg_addr);
  assign mean_off = 16'(reg_addr - MEAN_ADR);

  always_ff @(posedge ref_clk) begin
    if (srst) begin
      for (int i = 0; i < NREG; i++) begin
        regs_r[i] <= REG_RST[i];
      end
    end else if (reg_wr && acc_idx >= 0) begin
      regs_r[acc_idx] <= reg_wdata & REG_MASK[acc_idx];
    end
  end

  always_ff @(posedge ref_clk) begin
    if (srst) begin
      reg_rdata_r <= 8'h00;
    end else if (reg_rd) begin
      if (acc_idx >= 0) begin
        reg_rdata_r <= regs_r[acc_idx];
      end else if (mean_off < 16'(NMEAN)) begin
        reg_rdata_r <= mean_r[mean_off[1:0]];
      end else begin
        reg_rdata_r <= 8'h00;
      end
    end
  end

  // ---------------------------------------------------------------
  // field view and frame-start shadow
  // ---------------------------------------------------------------
  swpa_cfg_t cfg_c, act_r, use_c;

  function automatic logic [11:0] w12(int i);
    return {regs_r[i][3:0], regs_r[i+1]};
  endfunction

  always_comb begin
    cfg_c = '0;
    cfg_c.cbeg_c = w12(IX_CBEGC);
    cfg_c.cbeg_r = w12(IX_CBEGR);
    cfg_c.clast_c = w12(IX_CLASTC);
    cfg_c.clast_r = w12(IX_CLASTR);
    cfg_c.ow = w12(IX_OW);
    cfg_c.oh = w12(IX_OH);
    cfg_c.llen = {regs_r[IX_LLEN], regs_r[IX_LLEN+1]};
    cfg_c.flen = {regs_r[IX_FLEN][6:0], regs_r[IX_FLEN+1]};
    cfg_c.csh = w12(IX_CSH);
    cfg_c.rsh = w12(IX_RSH);
    cfg_c.cso = regs_r[IX_CSO][4:0];
    cfg_c.cse = regs_r[IX_CSE][4:0];
    cfg_c.rso = regs_r[IX_RSO][4:0];
    cfg_c.rse = regs_r[IX_RSE][4:0];
    cfg_c.pctl = regs_r[IX_PCTL];
    cfg_c.paux = regs_r[IX_PAUX];
    cfg_c.mx = {regs_r[IX_MX][0], regs_r[IX_MX+1]};
    cfg_c.my = regs_r[IX_MY];
    cfg_c.mw = {regs_r[IX_MW][0], regs_r[IX_MW+1]};
    cfg_c.mh = regs_r[IX_MH];
  end

  logic acc;
  assign acc = in_vld && in_rdy;
  // the start-of-frame pixel already sees the new settings
  assign use_c = in_pix.sof ? cfg_c : act_r;

  always_ff @(posedge ref_clk) begin
    if (srst) begin
      act_r <= '0;
    end else if (acc && in_pix.sof) begin
      act_r <= cfg_c;
    end
  end

  // ---------------------------------------------------------------
  // sensor timing position
  // ---------------------------------------------------------------
  logic [15:0] col_r, cur_col;
  logic [14:0] row_r, cur_row;
  logic line_end;

  assign cur_col = in_pix.sof ? 16'h0000 : col_r;
  assign cur_row = in_pix.sof ? 15'h0000 : row_r;
  assign line_end = cur_col == 16'(use_c.llen - 16'h0001);

  always_ff @(posedge ref_clk) begin
    if (srst) begin
      col_r <= 16'h0000;
      row_r <= 15'h0000;
    end else if (acc) begin
      col_r <= line_end ? 16'h0000 : 16'(cur_col + 16'h0001);
      if (line_end) begin
        row_r <= (cur_row == 15'(use_c.flen - 15'h0001)) ? 15'h0000 :
                 15'(cur_row + 15'h0001);
      end
    end
  end

  // ---------------------------------------------------------------
  // window, shift and step selection
  // ---------------------------------------------------------------
  function automatic logic [4:0] stepm1(logic [4:0] s);
    return (s == 5'h00) ? 5'h00 : 5'(s - 5'h01);
  endfunction

  logic cut;
  logic [11:0] lo_c, lo_r, oc, orr, ocol_r, orow_r;
  logic [4:0] cs, rs, cskip_r, rskip_r;
  logic col_in, row_in, col_take, row_take, keep;

  assign cut = use_c.paux[AUX_CUT];
  assign lo_c = 12'(use_c.cbeg_c + (cut ? use_c.csh : 12'h000));
  assign lo_r = 12'(use_c.cbeg_r + (cut ? use_c.rsh : 12'h000));
  assign cs = (cur_col == 16'h0000) ? 5'h00 : cskip_r;
  assign oc = (cur_col == 16'h0000) ? 12'h000 : ocol_r;
  assign rs = in_pix.sof ? 5'h00 : rskip_r;
  assign orr = in_pix.sof ? 12'h000 : orow_r;
  assign col_in = cur_col >= {4'h0, lo_c} &&
                  cur_col <= {4'h0, use_c.clast_c} &&
                  (!cut || oc < use_c.ow);
  assign row_in = cur_row >= {3'h0, lo_r} &&
                  cur_row <= {3'h0, use_c.clast_r} &&
                  (!cut || orr < use_c.oh);
  assign col_take = col_in && cs == 5'h00;
  assign row_take = row_in && rs == 5'h00;
  assign keep = col_take && row_take;

  always_ff @(posedge ref_clk) begin
    if (srst) begin
      cskip_r <= 5'h00;
      ocol_r <= 12'h000;
    end else if (acc) begin
      ocol_r <= 12'(oc + {11'h000, col_take});
      if (col_in && col_take) begin
        cskip_r <= stepm1(oc[0] ? use_c.cso : use_c.cse);
      end else if (col_in) begin
        cskip_r <= 5'(cs - 5'h01);
      end else begin
        cskip_r <= cs;
      end
    end
  end

  always_ff @(posedge ref_clk) begin
    if (srst) begin
      rskip_r <= 5'h00;
      orow_r <= 12'h000;
    end else if (acc && line_end) begin
      orow_r <= 12'(orr + {11'h000, row_take});
      if (row_in && row_take) begin
        rskip_r <= stepm1(orr[0] ? use_c.rso : use_c.rse);
      end else if (row_in) begin
        rskip_r <= 5'(rs - 5'h01);
      end else begin
        rskip_r <= rs;
      end
    end else if (acc && in_pix.sof) begin
      rskip_r <= 5'h00;
      orow_r <= 12'h000;
    end
  end

  // ---------------------------------------------------------------
  // test pattern
  // ---------------------------------------------------------------
  localparam logic [PIXW-1:0] PMAX = '1;
  logic [15:0] lfsr_r;
  logic [11:0] roll_r;
  logic [1:0] chan;
  logic [2:0] rgb;
  logic [9:0] ramp, pat, mix, fin;
  logic tile;

  // bayer order: blue on even/even, red on odd/odd
  assign chan = (orr[0] && oc[0]) ? 2'd2 :
                (!orr[0] && !oc[0]) ? 2'd0 : 2'd1;
  assign tile = oc[TILE_BIT] ^ orr[TILE_BIT];

  always_comb begin
    rgb = BAR_TABLE[3*oc[BAR_SHIFT+:3] +: 3];
    unique case (use_c.pctl[PC_STY+:2])
      2'b00: ramp = 10'h000;
      2'b01: ramp = orr[11:2];
      2'b10: ramp = 10'((use_c.ow - oc) >> 2);
      2'b11: ramp = 10'((use_c.oh - orr) >> 2);
    endcase
    pat = 10'h000;
    unique case (swpa_pat_t'(use_c.pctl[PC_MODE+:2]))
      PAT_BAR: begin
        pat = (rgb[chan] && PMAX > ramp) ? 10'(PMAX - ramp) : 10'h000;
      end
      PAT_RAND: pat = lfsr_r[PIXW-1:0];
      PAT_SQUARE: begin
        if (use_c.pctl[PC_MONO]) begin
          pat = tile ? PMAX : 10'h000;
        end else begin
          rgb = BAR_TABLE[3*{oc[TILE_BIT+1], tile, orr[TILE_BIT]} +: 3];
          pat = rgb[chan] ? PMAX : 10'h000;
        end
      end
      PAT_BLACK: pat = 10'h000;
    endcase
    mix = use_c.pctl[PC_TRANS] ?
          10'(({1'b0, pat} + {1'b0, in_pix.data}) >> 1) : pat;
    if (use_c.pctl[PC_ROLL] && orr >= roll_r &&
        orr < 12'(roll_r + ROLL_H)) begin
      mix = ~mix;
    end
    fin = use_c.pctl[PC_EN] ? mix : in_pix.data;
    if (use_c.paux[AUX_LSB0]) begin
      fin[1:0] = 2'b00;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (srst) begin
      lfsr_r <= LFSR_RST;
    end else if (acc && in_pix.sof && use_c.paux[AUX_SAME]) begin
      lfsr_r <= {LFSR_FILL, use_c.paux[3:0]};
    end else if (acc && keep) begin
      lfsr_r <= lfsr_r[0] ? ((lfsr_r >> 1) ^ LFSR_TAPS) : (lfsr_r >> 1);
    end
  end

  always_ff @(posedge ref_clk) begin
    if (srst) begin
      roll_r <= 12'h000;
    end else if (acc && in_pix.sof) begin
      roll_r <= (12'(roll_r + ROLL_STEP) >= use_c.oh) ? 12'h000 :
                12'(roll_r + ROLL_STEP);
    end
  end

  // ---------------------------------------------------------------
  // output stage and buffer
  // ---------------------------------------------------------------
  logic st_vld_r, sof_pend_r;
  swpa_pix_t st_pix_r;

  always_ff @(posedge ref_clk) begin
    if (srst) begin
      st_vld_r <= 1'b0;
      st_pix_r <= '0;
      sof_pend_r <= 1'b0;
    end else begin
      st_vld_r <= acc && keep;
      if (acc && keep) begin
        st_pix_r <= '{sof: in_pix.sof || sof_pend_r, data: fin};
      end
      if (acc && keep) begin
        sof_pend_r <= 1'b0;
      end else if (acc && in_pix.sof) begin
        sof_pend_r <= 1'b1;
      end
    end
  end

  swpa_fifo #(.W($bits(swpa_pix_t)), .D(DEPTH)) u_fifo (
    .ref_clk(ref_clk),
    .srst(srst),
    .wr_vld(st_vld_r),
    .wr_rdy(in_rdy),
    .wr_data(st_pix_r),
    .rd_vld(out_vld),
    .rd_rdy(out_rdy),
    .rd_data(out_pix)
  );

  // ---------------------------------------------------------------
  // window averages
  // ---------------------------------------------------------------
  logic [27:0] sum_r [3];
  logic [19:0] cnt_r [3];
  logic in_avg;
  logic [9:0] m [3];

  assign in_avg = keep &&
                  oc >= {3'h0, use_c.mx} &&
                  oc < 12'({3'h0, use_c.mx} + {3'h0, use_c.mw}) &&
                  orr >= {4'h0, use_c.my} &&
                  orr < 12'({4'h0, use_c.my} + {4'h0, use_c.mh});

  always_comb begin
    for (int c = 0; c < 3; c++) begin
      m[c] = (cnt_r[c] == 20'h00000) ? 10'h000 :
             10'(sum_r[c] / {8'h00, cnt_r[c]});
    end
  end

  always_ff @(posedge ref_clk) begin
    if (srst) begin
      for (int c = 0; c < 3; c++) begin
        sum_r[c] <= 28'h0000000;
        cnt_r[c] <= 20'h00000;
      end
    end else if (acc) begin
      for (int c = 0; c < 3; c++) begin
        if (in_avg && chan == 2'(c)) begin
          sum_r[c] <= 28'((in_pix.sof ? 28'h0 : sum_r[c]) + {18'h0, fin});
          cnt_r[c] <= 20'((in_pix.sof ? 20'h0 : cnt_r[c]) + 20'h1);
        end else if (in_pix.sof) begin
          sum_r[c] <= 28'h0000000;
          cnt_r[c] <= 20'h00000;
        end
      end
    end
  end

  always_ff @(posedge ref_clk) begin
    if (srst) begin
      for (int c = 0; c < NMEAN; c++) begin
        mean_r[c] <= 8'h00;
      end
    end else if (acc && in_pix.sof) begin
      for (int c = 0; c < 3; c++) begin
        mean_r[c] <= m[c][9:2];
      end
      mean_r[3] <= 8'(({2'b00, m[0]} + {1'b0, m[1], 1'b0} +
                       {2'b00, m[2]}) >> 4);
    end
  end

  // ---------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (srst);

  sequence sof_taken;
    acc && in_pix.sof;
  endsequence

  chk_crop_reset: assert property ($fell(srst) |->
    cfg_c.cbeg_r == 12'h004 && cfg_c.clast_c == 12'h7F3 &&
    cfg_c.clast_r == 12'h443 && cfg_c.ow == 12'h780)
    else $error("crop or size reset value wrong");
  chk_mask_outside: assert property (acc && !keep |=> !st_vld_r)
    else $error("pixel outside window was pushed");
  chk_sensor_pass: assert property (acc && keep && !use_c.pctl[PC_EN] &&
    !use_c.paux[AUX_LSB0] |=> st_pix_r.data == $past(in_pix.data))
    else $error("sensor data altered with pattern off");
  chk_black_mode: assert property (acc && keep &&
    use_c.pctl[7:5] == 3'b100 && use_c.pctl[1:0] == 2'b11
    |=> st_vld_r && st_pix_r.data == 10'h000)
    else $error("black pattern not zero");
  chk_lsb_clear: assert property (acc && keep && use_c.paux[AUX_LSB0]
    |=> st_pix_r.data[1:0] == 2'b00)
    else $error("low bits not cleared");
  chk_write_apply: assert property (reg_wr &&
    reg_addr == REG_ADR[IX_PCTL] |=> cfg_c.pctl == $past(reg_wdata))
    else $error("pattern control write not applied");
  chk_mean_read: assert property (reg_rd && reg_addr == MEAN_ADR
    |=> reg_rdata_r == $past(mean_r[0]))
    else $error("blue mean read wrong");
  chk_frame_latch: assert property (sof_taken |=> act_r == $past(cfg_c))
    else $error("settings not latched at frame start");
  chk_line_wrap: assert property (acc && line_end |=> col_r == 16'h0000)
    else $error("column count did not wrap at line length");

endmodule
`default_nettype wire

// ---- verification/swpa_sink.sv ----
`default_nettype none
module swpa_sink
  import swpa_pkg::*;
(
  input wire logic ref_clk,
  input wire logic hold,
  input wire logic out_vld,
  output logic out_rdy,
  input wire swpa_pix_t out_pix
);
  timeunit 1ns;
  timeprecision 1ps;
  swpa_pix_t q[$];
  logic ph = 1'b0;
  // --------------------------------
  // backend: slow (every other cycle), stalled while held
  // --------------------------------
  always @(negedge ref_clk) ph <= ~ph;
  assign out_rdy = ~hold & ph;
  always @(posedge ref_clk) if (out_vld && out_rdy) q.push_back(out_pix);
endmodule
`default_nettype wire

// ---- verification/sensor_window_pattern_average_tb.sv ----
`default_nettype none
module sensor_window_pattern_average_tb
  import swpa_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic ref_clk = 0, srst = 1, reg_wr = 0, reg_rd = 0, in_vld = 0, hold = 0;
  logic [15:0] reg_addr = 16'h0000;
  logic [7:0] reg_wdata = 8'h00, reg_rdata_r, d;
  logic in_rdy, out_vld, out_rdy;
  swpa_pix_t in_pix = '0, out_pix;
  int err_total = 0, checks_done = 0, refused = 0;
  swpa_top #(.DEPTH(FIFO_DEPTH)) uut (.ref_clk(ref_clk), .srst(srst),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_rdata_r(reg_rdata_r), .in_vld(in_vld),
    .in_rdy(in_rdy), .in_pix(in_pix), .out_vld(out_vld),
    .out_rdy(out_rdy), .out_pix(out_pix));
  swpa_sink sink (.ref_clk(ref_clk), .hold(hold), .out_vld(out_vld),
    .out_rdy(out_rdy), .out_pix(out_pix));
  initial begin
    forever #5 ref_clk = ~ref_clk;
  end
  // --------------------------------
  // shared tasks
  // --------------------------------
  task automatic check(input logic [15:0] seen, exp, input string what);
    checks_done++;
    if (seen !== exp) begin
      err_total++;
      $display("CHECK FAILED t=%0t %s seen %h exp %h", $time, what, seen, exp);
    end
  endtask
  task automatic wr(input logic [15:0] a, input logic [7:0] v);
    @(negedge ref_clk);
    reg_wr = 1; reg_addr = a; reg_wdata = v;
    @(negedge ref_clk);
    reg_wr = 0;
  endtask
  task automatic rd(input logic [15:0] a, output logic [7:0] v);
    @(negedge ref_clk);
    reg_rd = 1; reg_addr = a;
    @(negedge ref_clk);
    reg_rd = 0;
    @(negedge ref_clk);
    v = reg_rdata_r;
  endtask
  task automatic cfg(input logic [7:0] cb, cl, rb, rl, aux, pc);
    logic [7:0] v[16];
    v = '{8'h00, cb, 8'h00, rb, 8'h00, cl, 8'h00, rl, 8'h07, 8'h80, 8'h04,
          8'h38, 8'h00, 8'h08, 8'h00, 8'h04};
    for (int i = 0; i < 16; i++) wr(REG_ADR[i], v[i]);
    wr(16'h5041, aux);
    wr(16'h5040, pc);
    sink.q.delete();
  endtask
  // one 8 x 4 frame; data encodes row and column, or a constant
  task automatic frame(input logic konst);
    for (int r = 0; r < 4; r++)
      for (int c = 0; c < 8; c++) begin
        @(negedge ref_clk);
        while (!in_rdy) begin
          in_vld = 0;
          refused++;
          @(negedge ref_clk);
        end
        in_vld = 1;
        in_pix.sof = (r == 0 && c == 0);
        in_pix.data = konst ? 10'h200 : 10'((r * 16 + c) * 4 + 3);
      end
    @(negedge ref_clk);
    in_vld = 0;
  endtask
  task automatic drain(input int n);
    for (int i = 0; i < 400 && sink.q.size() < n; i++) @(negedge ref_clk);
    repeat (10) @(negedge ref_clk);
    check(16'(sink.q.size()), 16'(n), "word count");
  endtask
  task automatic win_check(input int r0, r1, c0, c1, input logic lz);
    int k = 0;
    for (int r = r0; r <= r1; r++)
      for (int c = c0; c <= c1; c++) begin
        check(16'(sink.q[k]), {5'h00, k == 0, 10'((r * 16 + c) * 4
          + (lz ? 0 : 3))}, "pixel");
        k++;
      end
  endtask
  // --------------------------------
  // scenarios
  // --------------------------------
  task automatic t_regs();
    for (int i = 0; i < NREG; i++) begin
      rd(REG_ADR[i], d);
      check(16'(d), 16'(REG_RST[i]), "reset value");
      wr(REG_ADR[i], 8'hFF);
      rd(REG_ADR[i], d);
      check(16'(d), 16'(REG_MASK[i]), "field width");
      wr(REG_ADR[i], REG_RST[i]);
    end
    for (int i = 0; i < NMEAN; i++) begin
      wr(MEAN_ADR + 16'(i), 8'hFF);
      rd(MEAN_ADR + 16'(i), d);
      check(16'(d), 16'h0000, "result reset");
    end
    rd(16'h1234, d);
    check(16'(d), 16'h0000, "unmapped read");
    $display("test regs done");
  endtask
  task automatic t_mean();
    cfg(8'h00, 8'h07, 8'h00, 8'h03, 8'h00, 8'h00);
    frame(1);
    frame(1);
    frame(0);
    for (int i = 0; i < NMEAN; i++) begin
      rd(MEAN_ADR + 16'(i), d);
      check(16'(d), 16'h0080, "channel mean");
    end
    $display("test mean done");
  endtask
  task automatic t_fifo();
    cfg(8'h00, 8'h07, 8'h00, 8'h03, 8'h00, 8'h00);
    hold = 1;
    refused = 0;
    fork
      frame(0);
      begin
        repeat (40) @(negedge ref_clk);
        hold = 0;
      end
    join
    check(16'(refused > 0), 16'h0001, "fifo refused");
    drain(32);
    win_check(0, 3, 0, 7, 0);
    $display("test fifo done");
  endtask
  task automatic t_window(input logic [7:0] aux, pc);
    cfg(8'h02, 8'h05, 8'h01, 8'h02, aux, pc);
    frame(0);
    drain(8);
    if (pc[PC_EN])
      foreach (sink.q[k])
        check(16'(sink.q[k].data), 16'h0000, "black");
    else
      win_check(1, 2, 2, 5, aux[AUX_LSB0]);
    $display("test window %h %h done", aux, pc);
  endtask
  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", checks_done, err_total);
    if (err_total == 0 && checks_done > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  initial begin
    #300us;
    err_total++;
    tally_and_finish();
  end
  initial begin
    repeat (4) @(negedge ref_clk);
    srst = 0;
    t_regs();
    t_mean();
    t_fifo();
    t_window(8'h00, 8'h00);
    t_window(8'h20, 8'h00);
    t_window(8'h00, 8'h83);
    tally_and_finish();
  end
endmodule
`default_nettype wire
